// ### hw/caq_pkg.sv
// Shared constants for the charge acquisition sequencer.
// Assumes a single 250 MHz clock and a 16-bit register port.
package caq_pkg;
   // Timing
   localparam int CLK_MHZ = 250;
   localparam int CONV_NS = 400;
   localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] CONV_LAST = 8'(CONV_CYC - 1);
   // Buffer geometry: 32 slots of 64 words, 11-bit word address
   localparam int ADDR_W = 11;
   localparam int TWORD_W = 14;
   localparam logic [4:0] STEP_LAST = 5'h1f;
   localparam logic [5:0] WORD_ONE = 6'h01;
   localparam logic [5:0] SLOT_ONE = 6'h01;
   // Register offsets
   localparam logic [15:0] OFS_OUTBUF = 16'h0000;
   localparam logic [15:0] OFS_MCST = 16'h1004;
   localparam logic [15:0] OFS_INTLVL = 16'h100a;
   localparam logic [15:0] OFS_INTVEC = 16'h100c;
   localparam logic [15:0] OFS_STATUS = 16'h100e;
   localparam logic [15:0] OFS_EVCNT_L = 16'h1024;
   localparam logic [15:0] OFS_EVCNT_H = 16'h1026;
   localparam logic [15:0] OFS_BITSET2 = 16'h1032;
   localparam logic [15:0] OFS_BITCLR2 = 16'h1034;
   localparam logic [15:0] OFS_WTEST = 16'h1036;
   localparam logic [15:0] OFS_TWHI = 16'h1038;
   localparam logic [15:0] OFS_TWLO = 16'h103a;
   localparam logic [15:0] OFS_TESTEVT = 16'h103e;
   localparam logic [15:0] OFS_EVCRST = 16'h1040;
   localparam logic [15:0] OFS_RTEST = 16'h1064;
   localparam logic [15:0] OFS_SWCOMM = 16'h1068;
   localparam logic [9:0] THR_PAGE = 10'h042;
   // Control-set register fields, and the threshold kill bit
   localparam int B2_MEMTEST = 0;
   localparam int B2_OVSUPP = 3;
   localparam int B2_ZSUPP = 4;
   localparam int B2_ACQTEST = 6;
   localparam int B2_EMPTY = 12;
   localparam int B2_CNTALL = 14;
   localparam int THR_KILL = 8;
   // Reset values
   localparam logic [15:0] BITSET2_RST = 16'h4000;
   localparam logic [7:0] MCST_RST = 8'haa;
   localparam logic [2:0] INTLVL_RST = 3'h0;
   localparam logic [7:0] INTVEC_RST = 8'h00;
   // Output word types, bits 26:24
   localparam logic [2:0] TY_DATA = 3'h0;
   localparam logic [2:0] TY_HDR = 3'h2;
   localparam logic [2:0] TY_END = 3'h4;
   localparam logic [31:0] INVALID_WORD = 32'h0600_0000;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CONV = 3'b001,
      ST_SEL = 3'b010,
      ST_EVAL = 3'b011,
      ST_HDR = 3'b100,
      ST_END = 3'b101,
      ST_RELEASE = 3'b110
   } caq_state_e;
endpackage

// ### hw/caq_buf_if.sv
// Port bundle between the sequencer and the multi-event buffer.
// Assumes one write port and one synchronous read port.
`timescale 1ns/1ps
interface caq_buf_if;
   logic wrEn;
   logic [caq_pkg::ADDR_W-1:0] wrAddr;
   logic [31:0] wrData;
   logic [caq_pkg::ADDR_W-1:0] rdAddr;
   logic [31:0] rdData;
   modport ctrl (output wrEn, output wrAddr, output wrData,
                 output rdAddr, input rdData);
   modport mem (input wrEn, input wrAddr, input wrData,
                output rdData, input rdAddr);
endinterface

// ### hw/caq_event_buffer.sv
// Multi-event buffer storage, 2048 words of 32 bits.
// Assumes the sequencer owns all pointers; contents have no reset.
`timescale 1ns/1ps
module caq_event_buffer (
   // Clock
   input wire logic clk,
   // Buffer port
   caq_buf_if.mem memPort
);
   logic [31:0] mem [0:(1<<caq_pkg::ADDR_W)-1];
   logic [31:0] rdData_q;

   always_ff @(posedge clk)
   begin
      if (memPort.wrEn)
         mem[memPort.wrAddr] <= memPort.wrData;
      rdData_q <= mem[memPort.rdAddr];
   end

   assign memPort.rdData = rdData_q;
endmodule

// ### hw/caq_test_fifo.sv
// Circular 32-entry test-event FIFO with separately cleared pointers.
// Assumes the caller gates stepping and loading by the test select.
`timescale 1ns/1ps
module caq_test_fifo (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pointer control
   input wire logic wrPtrClr,
   input wire logic rdPtrClr,
   // Load side
   input wire logic wrStrobe,
   input wire logic [caq_pkg::TWORD_W-1:0] wrWord,
   // Replay side
   input wire logic rdStep,
   output logic [caq_pkg::TWORD_W-1:0] rdWord
);
   logic [caq_pkg::TWORD_W-1:0] mem [0:31];
   logic [4:0] wrPtr_q;
   logic [4:0] rdPtr_q;

   // Pointers wrap, so extra loads overwrite the oldest entries
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         wrPtr_q <= 5'h00;
      else if (wrPtrClr)
         wrPtr_q <= 5'h00;
      else if (wrStrobe)
         wrPtr_q <= wrPtr_q + 5'h01;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rdPtr_q <= 5'h00;
      else if (rdPtrClr)
         rdPtr_q <= 5'h00;
      else if (rdStep)
         rdPtr_q <= rdPtr_q + 5'h01;
   end

   always_ff @(posedge clk)
   begin
      if (wrStrobe && !wrPtrClr)
         mem[wrPtr_q] <= wrWord;
   end

   assign rdWord = mem[rdPtr_q];
endmodule

// ### hw/caq_sequencer.sv
// Charge acquisition sequencer: gate, conversion, scan, event storage.
// Assumes gate and fast clear are asynchronous pins, converter results
// arrive on this clock one cycle after the channel select.
//
// Notes on behaviour
// (RULE1) Reset zeroes event counter, empties buffer, both pointers at slot 0.
// (RULE2) Reset loads interrupt level zero and interrupt vector zero.
// (RULE3) Reset presets the broadcast upper address field to 0xAA.
// (RULE4) Software programs every channel threshold; they have no reset.
// (RULE5) Gate while idle starts conversion, counts event, raises busy.
// (RULE6) Reset or fast clear during conversion cancels the scan.
// (RULE7) Scan samples channels and filters by suppression and kill bits.
// (RULE8) Accepted values stored between a header and an end-of-block word.
// (RULE9) No accepted value and empty-event off: nothing is written.
// (RULE10) No accepted value and empty-event on: header and end word only.
// (RULE11) Buffer not full clears busy; full holds busy and ignores gates.
// (RULE12) Control bit 0 enables direct buffer access test mode.
// (RULE13) Software loads the 11-bit test write address first.
// (RULE14) Writing the low half stores the full 32-bit test word.
// (RULE15) Test read and write addresses must differ; software's duty.
// (RULE16) Control bit 6 replaces channel inputs with the test FIFO.
// (RULE17) Setting bit 6 selects acquisition test, clears FIFO write pointer.
// (RULE18) Clearing bit 6 clears read pointer and enables FIFO loading.
// (RULE19) Software loads exactly 32 words into the circular FIFO.
// (RULE20) Channel order interleaves halves: 0, 16, 1, 17 up to 31.
// (RULE21) Each test word holds a 13-bit value and an overflow flag.
// (RULE22) Setting bit 6 again lets each gate replay the FIFO as an event.
// (RULE23) Counter counts every gate when mode bit is 1, else accepted ones.
`timescale 1ns/1ps
module caq_sequencer (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Front panel
   input wire logic gatePin,
   input wire logic fastClearPin,
   output logic busy,
   // Conversion sections
   output logic convStart,
   output logic sectionClear,
   output logic [4:0] chanSel,
   input wire logic [12:0] chanValue,
   input wire logic chanOverflow,
   // Register port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [15:0] regAddr,
   input wire logic [15:0] regWrData,
   output logic [31:0] regRdData,
   output logic regRdValid,
   // Setup state
   output logic [2:0] intLevel,
   output logic [7:0] intVector,
   output logic [7:0] mcstAddr
);
   caq_pkg::caq_state_e state_q, state_d;
   logic gateS1_q, gateS2_q, gateS3_q, clrS1_q, clrS2_q;
   logic [15:0] bitSet2_q, bitSet2_d, twHi_q;
   logic [10:0] wTestAddr_q, rTestAddr_q;
   logic [8:0] thr_q [0:31];
   logic [23:0] evCnt_q;
   logic [7:0] convCnt_q;
   logic [4:0] step_q;
   logic [5:0] nAcc_q, wrSlot_q, rdSlot_q, rdWord_q;
   logic acqPrev_q, busy_q, convStart_q, sectionClear_q;
   logic rdPend_q, rdIsBuf_q, rdEmpty_q, regRdValid_q;
   logic [31:0] rdReg_q, regRdData_q, seqData, regMux;
   logic [13:0] fifoWord;
   logic [12:0] evalVal;
   logic [8:0] thrCh;
   logic [5:0] wordIdx;
   logic wBitSet, wBitClr, testWr, seqWr, gateEvt, takeGate, evcRst;
   logic memTest, acqTest, acqRise, acqFall, countEvery, emptyEn;
   logic evalOv, accept, frameNeeded, full, empty, cntInc, isThr;

   caq_buf_if bufBus();

   caq_event_buffer u_buffer (
      .clk(clk),
      .memPort(bufBus)
   );

   caq_test_fifo u_fifo (
      .clk(clk),
      .nrst(nrst),
      .wrPtrClr(acqRise), // [RULE17] [RULE22]
      .rdPtrClr(acqFall), // [RULE18]
      .wrStrobe(regWrite && regAddr == caq_pkg::OFS_TESTEVT && !acqTest),
      .wrWord(regWrData[caq_pkg::TWORD_W-1:0]),
      .rdStep(state_q == caq_pkg::ST_EVAL && acqTest), // [RULE22]
      .rdWord(fifoWord)
   );

   // Register write decode
   assign wBitSet = regWrite && regAddr == caq_pkg::OFS_BITSET2;
   assign wBitClr = regWrite && regAddr == caq_pkg::OFS_BITCLR2;
   assign evcRst = regWrite && regAddr == caq_pkg::OFS_EVCRST;
   assign isThr = regAddr[15:6] == caq_pkg::THR_PAGE && !regAddr[0];
   assign bitSet2_d = wBitSet ? (bitSet2_q | regWrData)
                    : wBitClr ? (bitSet2_q & ~regWrData) : bitSet2_q;
   assign memTest = bitSet2_q[caq_pkg::B2_MEMTEST]; // [RULE12]
   assign acqTest = bitSet2_q[caq_pkg::B2_ACQTEST]; // [RULE16]
   assign countEvery = bitSet2_q[caq_pkg::B2_CNTALL];
   assign emptyEn = bitSet2_q[caq_pkg::B2_EMPTY];
   assign acqRise = acqTest && !acqPrev_q;
   assign acqFall = !acqTest && acqPrev_q;

   // Gate handling; the software command acts as a gate
   assign gateEvt = (gateS2_q && !gateS3_q)
                  || (regWrite && regAddr == caq_pkg::OFS_SWCOMM);
   assign takeGate = gateEvt && state_q == caq_pkg::ST_IDLE
                   && !memTest; // [RULE5] [RULE11]
   assign cntInc = countEvery ? gateEvt : takeGate; // [RULE23]
   assign full = wrSlot_q[5] != rdSlot_q[5]
               && wrSlot_q[4:0] == rdSlot_q[4:0];
   assign empty = wrSlot_q == rdSlot_q;

   // Channel filter; test mode feeds FIFO words instead of inputs
   assign chanSel = {step_q[0], step_q[4:1]}; // [RULE20]
   assign evalVal = acqTest ? fifoWord[12:0] : chanValue; // [RULE21]
   assign evalOv = acqTest ? fifoWord[13] : chanOverflow;
   assign thrCh = thr_q[chanSel];
   assign accept = !thrCh[caq_pkg::THR_KILL]
      && !(bitSet2_q[caq_pkg::B2_ZSUPP] && evalVal < {thrCh[7:0], 5'h00})
      && !(bitSet2_q[caq_pkg::B2_OVSUPP] && evalOv); // [RULE7]
   assign frameNeeded = nAcc_q != 6'h00 || emptyEn; // [RULE9] [RULE10]

   // Event word writes
   assign seqWr = (state_q == caq_pkg::ST_EVAL && accept)
                || (state_q == caq_pkg::ST_HDR && frameNeeded)
                || state_q == caq_pkg::ST_END; // [RULE8]
   assign wordIdx = state_q == caq_pkg::ST_HDR ? 6'h00
                  : nAcc_q + caq_pkg::WORD_ONE;
   assign seqData = state_q == caq_pkg::ST_EVAL
      ? {5'h00, caq_pkg::TY_DATA, 3'h0, chanSel, 2'h0, evalOv, evalVal}
      : state_q == caq_pkg::ST_HDR
      ? {5'h00, caq_pkg::TY_HDR, 10'h000, nAcc_q, 8'h00}
      : {5'h00, caq_pkg::TY_END, evCnt_q};
   assign testWr = regWrite && regAddr == caq_pkg::OFS_TWLO && memTest;
   assign bufBus.wrEn = testWr || seqWr;
   assign bufBus.wrAddr = testWr ? wTestAddr_q
                        : {wrSlot_q[4:0], wordIdx};
   assign bufBus.wrData = testWr ? {twHi_q, regWrData}
                        : seqData; // [RULE14]
   assign bufBus.rdAddr = memTest ? rTestAddr_q
                        : {rdSlot_q[4:0], rdWord_q};

   // Register read selection
   assign regMux = isThr ? {23'h00_0000, thr_q[regAddr[5:1]]}
      : regAddr == caq_pkg::OFS_BITSET2 ? {16'h0000, bitSet2_q}
      : regAddr == caq_pkg::OFS_MCST ? {24'h00_0000, mcstAddr}
      : regAddr == caq_pkg::OFS_INTLVL ? {29'h0000_0000, intLevel}
      : regAddr == caq_pkg::OFS_INTVEC ? {24'h00_0000, intVector}
      : regAddr == caq_pkg::OFS_STATUS ? {29'h0000_0000, full, empty,
                                          busy_q}
      : regAddr == caq_pkg::OFS_EVCNT_L ? {16'h0000, evCnt_q[15:0]}
      : regAddr == caq_pkg::OFS_EVCNT_H ? {24'h00_0000, evCnt_q[23:16]}
      : 32'h0000_0000;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         caq_pkg::ST_IDLE:
            if (takeGate)
               state_d = caq_pkg::ST_CONV;
         caq_pkg::ST_CONV:
            if (clrS2_q)
               state_d = caq_pkg::ST_IDLE; // [RULE6]
            else if (convCnt_q == caq_pkg::CONV_LAST)
               state_d = caq_pkg::ST_SEL;
         caq_pkg::ST_SEL:
            state_d = caq_pkg::ST_EVAL;
         caq_pkg::ST_EVAL:
            if (step_q == caq_pkg::STEP_LAST)
               state_d = caq_pkg::ST_HDR;
            else
               state_d = caq_pkg::ST_SEL;
         caq_pkg::ST_HDR:
            state_d = frameNeeded ? caq_pkg::ST_END : caq_pkg::ST_RELEASE;
         caq_pkg::ST_END:
            state_d = caq_pkg::ST_RELEASE;
         caq_pkg::ST_RELEASE:
            if (!full)
               state_d = caq_pkg::ST_IDLE; // [RULE11]
         default:
            state_d = caq_pkg::ST_IDLE;
      endcase
   end

   // Pins cross in through two flops; stage one feeds stage two only
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         {gateS1_q, gateS2_q, gateS3_q} <= 3'h0;
         {clrS1_q, clrS2_q} <= 2'h0;
      end
      else
      begin
         {gateS1_q, gateS2_q, gateS3_q} <= {gatePin, gateS1_q, gateS2_q};
         {clrS1_q, clrS2_q} <= {fastClearPin, clrS1_q};
      end
   end

   // Setup and test registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bitSet2_q <= caq_pkg::BITSET2_RST;
         acqPrev_q <= 1'b0;
         intLevel <= caq_pkg::INTLVL_RST; // [RULE2]
         intVector <= caq_pkg::INTVEC_RST; // [RULE2]
         mcstAddr <= caq_pkg::MCST_RST; // [RULE3]
         {wTestAddr_q, rTestAddr_q} <= 22'h00_0000;
         twHi_q <= 16'h0000;
      end
      else
      begin
         bitSet2_q <= bitSet2_d;
         acqPrev_q <= acqTest;
         if (regWrite && regAddr == caq_pkg::OFS_INTLVL)
            intLevel <= regWrData[2:0];
         if (regWrite && regAddr == caq_pkg::OFS_INTVEC)
            intVector <= regWrData[7:0];
         if (regWrite && regAddr == caq_pkg::OFS_MCST)
            mcstAddr <= regWrData[7:0];
         if (regWrite && regAddr == caq_pkg::OFS_WTEST)
            wTestAddr_q <= regWrData[10:0];
         if (regWrite && regAddr == caq_pkg::OFS_RTEST)
            rTestAddr_q <= regWrData[10:0];
         if (regWrite && regAddr == caq_pkg::OFS_TWHI)
            twHi_q <= regWrData;
      end
   end

   // Thresholds keep their contents through reset by design
   always_ff @(posedge clk)
   begin
      if (regWrite && isThr)
         thr_q[regAddr[5:1]] <= regWrData[8:0];
   end

   // Sequencer and event counter
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= caq_pkg::ST_IDLE;
         evCnt_q <= 24'h00_0000; // [RULE1]
         convCnt_q <= 8'h00;
         step_q <= 5'h00;
         nAcc_q <= 6'h00;
         wrSlot_q <= 6'h00; // [RULE1]
         {busy_q, convStart_q, sectionClear_q} <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         if (cntInc)
            evCnt_q <= evcRst ? 24'h00_0001 : evCnt_q + 24'h00_0001;
         else if (evcRst)
            evCnt_q <= 24'h00_0000;
         convCnt_q <= state_q == caq_pkg::ST_CONV
                    ? convCnt_q + 8'h01 : 8'h00;
         if (state_q == caq_pkg::ST_EVAL)
            step_q <= step_q + 5'h01;
         if (state_q == caq_pkg::ST_CONV)
            nAcc_q <= 6'h00;
         else if (state_q == caq_pkg::ST_EVAL && accept)
            nAcc_q <= nAcc_q + caq_pkg::WORD_ONE;
         if (state_q == caq_pkg::ST_END)
            wrSlot_q <= wrSlot_q + caq_pkg::SLOT_ONE;
         busy_q <= state_d != caq_pkg::ST_IDLE; // [RULE5] [RULE11]
         convStart_q <= takeGate;
         sectionClear_q <= (state_q == caq_pkg::ST_CONV && clrS2_q)
            || (state_q == caq_pkg::ST_RELEASE && !full);
      end
   end

   // Reads answer two cycles later; buffer reads walk the oldest event
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         {rdPend_q, rdIsBuf_q, rdEmpty_q, regRdValid_q} <= 4'h0;
         rdReg_q <= 32'h0000_0000;
         regRdData_q <= 32'h0000_0000;
         rdSlot_q <= 6'h00; // [RULE1]
         rdWord_q <= 6'h00;
      end
      else
      begin
         rdPend_q <= regRead;
         rdIsBuf_q <= regRead && regAddr == caq_pkg::OFS_OUTBUF;
         rdEmpty_q <= empty;
         rdReg_q <= regMux;
         regRdValid_q <= rdPend_q;
         if (rdPend_q)
            regRdData_q <= !rdIsBuf_q ? rdReg_q
               : (rdEmpty_q && !memTest) ? caq_pkg::INVALID_WORD
               : bufBus.rdData;
         if (rdIsBuf_q && !memTest && !rdEmpty_q)
         begin
            if (bufBus.rdData[26:24] == caq_pkg::TY_END)
            begin
               rdSlot_q <= rdSlot_q + caq_pkg::SLOT_ONE;
               rdWord_q <= 6'h00;
            end
            else
               rdWord_q <= rdWord_q + caq_pkg::WORD_ONE;
         end
      end
   end

   assign busy = busy_q;
   assign convStart = convStart_q;
   assign sectionClear = sectionClear_q;
   assign regRdData = regRdData_q;
   assign regRdValid = regRdValid_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   AST_RESET_PTRS: assert property ($rose(nrst) |-> evCnt_q == 24'h00_0000 // [RULE1]
      && empty && rdWord_q == 6'h00) else $error("pointers not cleared");
   AST_RESET_INT: assert property ($rose(nrst) |-> intLevel == 3'h0 // [RULE2]
      && intVector == 8'h00) else $error("interrupt setup not zero");
   AST_RESET_MCST: assert property ($rose(nrst) // [RULE3]
      |-> mcstAddr == 8'haa) else $error("broadcast field not preset");
   AST_GATE_BUSY: assert property (takeGate |=> busy && convStart // [RULE5]
      && state_q == caq_pkg::ST_CONV) else $error("gate not taken");
   AST_ABORT: assert property (state_q == caq_pkg::ST_CONV && clrS2_q // [RULE6]
      |=> !busy && sectionClear && state_q == caq_pkg::ST_IDLE)
      else $error("fast clear did not abort");
   AST_NO_EMPTY: assert property (state_q == caq_pkg::ST_HDR // [RULE9]
      && nAcc_q == 6'h00 && !emptyEn |-> !seqWr ##1 $stable(wrSlot_q))
      else $error("empty event was stored");
   AST_EMPTY_FRAME: assert property (state_q == caq_pkg::ST_HDR // [RULE10]
      && nAcc_q == 6'h00 && emptyEn |-> bufBus.wrData[26:24]
      == caq_pkg::TY_HDR ##1 seqWr && bufBus.wrAddr[5:0] == 6'h01)
      else $error("empty frame malformed");
   AST_FULL_HOLD: assert property (state_q == caq_pkg::ST_RELEASE && full // [RULE11]
      |=> busy && !convStart) else $error("busy dropped while full");
   AST_TEST_WORD: assert property (testWr |-> bufBus.wrEn // [RULE14]
      && bufBus.wrAddr == wTestAddr_q
      && bufBus.wrData == {twHi_q, regWrData}) else $error("test word lost");
   AST_ORDER: assert property (state_q == caq_pkg::ST_EVAL // [RULE20]
      && step_q == 5'h01 |-> chanSel == 5'h10) else $error("bad order");
   AST_COUNT_ALL: assert property (gateEvt && countEvery && !evcRst // [RULE23]
      |=> evCnt_q == $past(evCnt_q) + 24'h00_0001)
      else $error("gate not counted");

   COV_ABORT: cover property (state_q == caq_pkg::ST_CONV && clrS2_q);
   COV_FULL: cover property (state_q == caq_pkg::ST_RELEASE && full);
   COV_EMPTY_FRAME: cover property (state_q == caq_pkg::ST_HDR
      && nAcc_q == 6'h00 && emptyEn);
   COV_REPLAY: cover property (acqTest && state_q == caq_pkg::ST_END);
endmodule

// ### tb/caq_qac_model.sv
// Conversion-section stand-in for the acquisition sequencer bench.
// Assumes the sequencer samples the result one clock after the select.
`timescale 1ns/1ps
module caq_section_model (
   // Clock
   input wire logic clk,
   // Channel side
   input wire logic [4:0] chanSel,
   input wire logic [12:0] base,
   output logic [12:0] chanValue,
   output logic chanOverflow
);
   // Result tracks the select, so a stale sample shows up as a mismatch
   always_ff @(posedge clk)
   begin
      chanValue <= base + 13'(chanSel);
      chanOverflow <= chanSel[4];
   end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the charge acquisition sequencer.
// Assumes caq_section_model answers the channel select.
`timescale 1ns/1ps
module testbench;
   logic clk, nrst, gatePin, fastClearPin, regWrite, regRead;
   logic [15:0] regAddr, regWrData;
   logic [12:0] base, chanValue;
   logic chanOverflow, busy, convStart, sectionClear, regRdValid;
   logic [4:0] chanSel;
   logic [31:0] regRdData, rd;
   logic [2:0] intLevel;
   logic [7:0] intVector, mcstAddr;
   logic [13:0] tw [32];
   int fail_count, checked, nStart, nClear;

   caq_sequencer DUT (.clk(clk), .nrst(nrst), .gatePin(gatePin),
      .fastClearPin(fastClearPin), .busy(busy), .convStart(convStart),
      .sectionClear(sectionClear), .chanSel(chanSel),
      .chanValue(chanValue), .chanOverflow(chanOverflow),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .intLevel(intLevel),
      .intVector(intVector), .mcstAddr(mcstAddr));
   caq_section_model SECTIONS (.clk(clk), .chanSel(chanSel), .base(base),
      .chanValue(chanValue), .chanOverflow(chanOverflow));

   // Pulse tallies for the one-cycle section controls
   always @(posedge clk)
   begin
      if (convStart === 1'b1)
         nStart <= nStart + 1;
      if (sectionClear === 1'b1)
         nClear <= nClear + 1;
   end

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // A wait that ran out ends the run
   task automatic lim(input int n, input int m);
      if (n == m)
      begin
         chk(32'h0, 32'h1);
         test_done();
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      regWrite = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge clk);
      regWrite = 1'b0;
      @(negedge clk);
   endtask

   task automatic rdr(input logic [15:0] a);
      int n;
      regRead = 1'b1;
      regAddr = a;
      @(negedge clk);
      regRead = 1'b0;
      n = 0;
      while (regRdValid !== 1'b1 && n < 4)
      begin
         @(negedge clk);
         n++;
      end
      lim(n, 4);
      rd = regRdData;
      @(negedge clk);
   endtask

   task automatic waitIdle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      lim(n, 1000);
   endtask

   // Long enough to pass the two-flop synchroniser
   task automatic gate();
      gatePin = 1'b1;
      repeat (4) @(negedge clk);
      gatePin = 1'b0;
      repeat (4) @(negedge clk);
   endtask

   task automatic thr(input logic [15:0] v);
      for (int c = 0; c < 32; c++)
         wr(16'h1080 + 16'(2 * c), v);
   endtask

   task automatic readEvent(input int n, input logic [23:0] cnt,
                            input logic acq);
      logic [4:0] ch;
      rdr(caq_pkg::OFS_OUTBUF);
      chk(32'(rd[26:24]), 32'(caq_pkg::TY_HDR));
      chk(32'(rd[13:8]), 32'(n));
      for (int k = 0; k < n; k++)
      begin
         ch = k[0] ? 5'(16 + k / 2) : 5'(k / 2);
         rdr(caq_pkg::OFS_OUTBUF);
         chk(32'({rd[26:24], rd[20:16], rd[13:0]}), acq ?
            32'({caq_pkg::TY_DATA, ch, tw[k]}) :
            32'({caq_pkg::TY_DATA, ch, ch[4], base + 13'(ch)}));
      end
      rdr(caq_pkg::OFS_OUTBUF);
      chk(32'(rd[26:24]), 32'(caq_pkg::TY_END));
      chk(32'(rd[23:0]), 32'(cnt));
   endtask

   initial
   begin
      nrst = 1'b0;
      gatePin = 1'b0;
      fastClearPin = 1'b0;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 16'h0000;
      regWrData = 16'h0000;
      base = 13'h0100;
      fail_count = 0;
      checked = 0;
      nStart = 0;
      nClear = 0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      chk(32'({intLevel, intVector}), 32'h0);
      chk(32'(mcstAddr), 32'h0000_00aa);
      rdr(caq_pkg::OFS_EVCNT_L);
      chk(rd, 32'h0);
      rdr(caq_pkg::OFS_OUTBUF);
      chk(rd, caq_pkg::INVALID_WORD);
      thr(16'h0000);
      gate();
      chk(32'(busy), 32'h1);
      waitIdle();
      readEvent(32, 24'h1, 1'b0);
      // Second gate lands while busy
      gate();
      gate();
      waitIdle();
      readEvent(32, 24'h3, 1'b0);
      wr(caq_pkg::OFS_BITCLR2, 16'h4000);
      gate();
      gate();
      waitIdle();
      readEvent(32, 24'h4, 1'b0);
      wr(caq_pkg::OFS_BITSET2, 16'h4000);
      gate();
      fastClearPin = 1'b1;
      @(negedge clk);
      fastClearPin = 1'b0;
      waitIdle();
      rdr(caq_pkg::OFS_OUTBUF);
      chk(rd, caq_pkg::INVALID_WORD);
      wr(caq_pkg::OFS_BITSET2, 16'h0010);
      thr(16'h00ff);
      gate();
      waitIdle();
      rdr(caq_pkg::OFS_OUTBUF);
      chk(rd, caq_pkg::INVALID_WORD);
      wr(caq_pkg::OFS_BITSET2, 16'h1000);
      gate();
      waitIdle();
      readEvent(0, 24'h7, 1'b0);
      wr(caq_pkg::OFS_BITCLR2, 16'h1010);
      wr(caq_pkg::OFS_BITSET2, 16'h0040);
      wr(caq_pkg::OFS_BITCLR2, 16'h0040);
      for (int k = 0; k < 32; k++)
      begin
         tw[k] = {k[1], 13'(k * 37 + 5)};
         wr(caq_pkg::OFS_TESTEVT, 16'(tw[k]));
      end
      wr(caq_pkg::OFS_BITSET2, 16'h0040);
      gate();
      waitIdle();
      readEvent(32, 24'h8, 1'b1);
      gate();
      waitIdle();
      readEvent(32, 24'h9, 1'b1);
      wr(caq_pkg::OFS_BITCLR2, 16'h0040);
      wr(caq_pkg::OFS_BITSET2, 16'h0001);
      wr(caq_pkg::OFS_RTEST, 16'h0007);
      wr(caq_pkg::OFS_WTEST, 16'h0005);
      wr(caq_pkg::OFS_TWHI, 16'hbeef);
      wr(caq_pkg::OFS_TWLO, 16'h0123);
      wr(caq_pkg::OFS_WTEST, 16'h0006);
      wr(caq_pkg::OFS_RTEST, 16'h0005);
      rdr(caq_pkg::OFS_OUTBUF);
      chk(rd, 32'hbeef_0123);
      wr(caq_pkg::OFS_BITCLR2, 16'h0001);
      // Empty events fill all 32 slots quickly
      wr(caq_pkg::OFS_BITSET2, 16'h1010);
      for (int k = 0; k < 32; k++)
      begin
         gate();
         if (k < 31)
            waitIdle();
      end
      repeat (400) @(negedge clk);
      chk(32'(busy), 32'h1);
      rdr(caq_pkg::OFS_STATUS);
      chk(rd, 32'h0000_0005);
      chk(32'(nStart), 32'd40);
      chk(32'(nClear), 32'd39);
      test_done();
   end
endmodule
